// ---- design/cck_consts.vh ----
`ifndef CCK_CONSTS_VH
`define CCK_CONSTS_VH

// register byte offsets
`define CCK_OFS_CFG        8'h00
`define CCK_OFS_PASS       8'h04
`define CCK_OFS_FAIL       8'h08
`define CCK_OFS_CAP_TX     8'h0c
`define CCK_OFS_CAP_RX     8'h10
`define CCK_OFS_LMR        8'h14
`define CCK_OFS_TX_SEQ     8'h18
`define CCK_OFS_RX_SEQ     8'h1c
`define CCK_OFS_PEER_ID    8'h20
`define CCK_OFS_GROUP_ID   8'h24
`define CCK_OFS_MODE       8'h28
`define CCK_OFS_LM_STAT    8'h2c

// config/status word fields
`define CCK_CFG_RESET      32'h0000_0100
`define CCK_CFG_WMASK      32'h0017_ffff
`define CCK_B_SEQ_CHK      20
`define CCK_F_MISS_HI      18
`define CCK_F_MISS_LO      16
`define CCK_F_PRIO_HI      15
`define CCK_F_PRIO_LO      13
`define CCK_F_PER_HI       12
`define CCK_F_PER_LO       10
`define CCK_B_GROUP_CHK    9
`define CCK_B_PEER_CHK     8
`define CCK_B_PER_ERR      7
`define CCK_B_PRIO_ERR     6
`define CCK_B_ZERO_ERR     5
`define CCK_B_RDI          4
`define CCK_B_PEER_ERR     2
`define CCK_B_GROUP_ERR    1
`define CCK_B_LEVEL_ERR    0

// mode register fields
`define CCK_B_UP_MODE      0
`define CCK_F_LEVEL_HI     3
`define CCK_F_LEVEL_LO     1

// lm status register fields (overruns and sequence sticky are write-1-to-clear)
`define CCK_B_LMM_VLD      0
`define CCK_B_CCLM_VLD     1
`define CCK_B_LMR_VLD      2
`define CCK_B_LMM_OVR      4
`define CCK_B_CCLM_OVR     5
`define CCK_B_LMR_OVR      6
`define CCK_B_SEQ_ERR      8

// received sequence tag positions in up-endpoint mode
`define CCK_F_TAG_CCLM_HI  20
`define CCK_F_TAG_CCLM_LO  16
`define CCK_F_TAG_LMR_HI   25
`define CCK_F_TAG_LMR_LO   21
`define CCK_F_TAG_LMM_HI   30
`define CCK_F_TAG_LMM_LO   26
`define CCK_SEQ_LOW_HI     15

`define CCK_MISS_LOC       3'h7
`define CCK_MISS_ONE       3'h1
`define CCK_PERIOD_ZERO    3'h0
`define CCK_ONE32          32'h0000_0001
`define CCK_ZERO32         32'h0000_0000

`endif

// ---- design/cck_rx_check_lm_capture.v ----
`timescale 1ns/1ps
`default_nettype none
`include "cck_consts.vh"

module cck_rx_check_lm_capture (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // received continuity check frame
  input  wire        rx_cc_valid,
  input  wire        rx_cc_lm,
  input  wire [15:0] rx_peer_id,
  input  wire [31:0] rx_group_id,
  input  wire [2:0]  rx_period,
  input  wire [2:0]  rx_priority,
  input  wire [2:0]  rx_level,
  input  wire        rx_remote_defect,
  input  wire [31:0] rx_sequence,
  input  wire [31:0] rx_far_tx_count,
  // loss measurement events
  input  wire        rx_lm_request,
  input  wire        rx_lm_reply,
  input  wire [4:0]  lm_rx_sequence_tag,
  input  wire        in_service,
  input  wire [31:0] rx_frame_counter,
  input  wire [31:0] rx_lm_counter,
  // continuity timing
  input  wire        half_period_tick,
  // transmit side values
  output reg  [31:0] tx_sequence,
  output reg  [31:0] far_tx_count,
  output reg  [31:0] local_rx_count,
  output reg         loss_of_continuity
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] cc_check_config_status;
  reg [31:0] cc_rx_pass_count;
  reg [31:0] cc_rx_fail_count;
  reg [31:0] captured_far_tx_count;
  reg [31:0] captured_local_rx_count;
  reg [31:0] up_reply_rx_count_sample;
  reg [31:0] cc_tx_sequence;
  reg [31:0] cc_rx_expected_sequence;
  reg [15:0] expected_peer_id;
  reg [31:0] expected_group_id;
  reg        up_mode;
  reg [2:0]  expected_level;
  reg        lm_request_sample_valid;
  reg        cc_lm_sample_valid;
  reg        lm_reply_sample_valid;
  reg        lm_request_sample_overrun;
  reg        cc_lm_sample_overrun;
  reg        lm_reply_sample_overrun;
  reg        rx_sequence_error_sticky;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = reg_wr && (reg_addr == ofs);
    end
  endfunction

  function rd_hit;
    input [7:0] ofs;
    begin
      rd_hit = reg_rd && (reg_addr == ofs);
    end
  endfunction

  // sticky: set wins over write-one clear
  function sticky_next;
    input cur;
    input set;
    input clr;
    begin
      sticky_next = set | (cur & ~clr);
    end
  endfunction

  // ----------------------------------------------------------------
  // frame checks
  // ----------------------------------------------------------------
  wire       peer_chk_en  = cc_check_config_status[`CCK_B_PEER_CHK];
  wire       group_chk_en = cc_check_config_status[`CCK_B_GROUP_CHK];
  wire       seq_chk_en   = cc_check_config_status[`CCK_B_SEQ_CHK];
  wire [2:0] cfg_period   = cc_check_config_status[`CCK_F_PER_HI:`CCK_F_PER_LO];
  wire [2:0] cfg_prio     = cc_check_config_status[`CCK_F_PRIO_HI:`CCK_F_PRIO_LO];
  wire [2:0] miss_cnt     = cc_check_config_status[`CCK_F_MISS_HI:`CCK_F_MISS_LO];

  wire peer_err  = peer_chk_en && (rx_peer_id != expected_peer_id);
  wire group_err = group_chk_en && (rx_group_id != expected_group_id);
  wire zero_err  = (rx_period == `CCK_PERIOD_ZERO);
  wire per_err   = !zero_err && (rx_period != cfg_period);
  wire prio_err  = (rx_priority != cfg_prio);
  wire level_err = (rx_level != expected_level);
  wire frame_bad = peer_err | group_err | zero_err | per_err | prio_err | level_err;
  wire frame_ok  = rx_cc_valid && !frame_bad;

  // up mode compares the low half only
  wire seq_mismatch = up_mode ?
    (rx_sequence[`CCK_SEQ_LOW_HI:0] != cc_rx_expected_sequence[`CCK_SEQ_LOW_HI:0]) :
    (rx_sequence != cc_rx_expected_sequence);
  wire seq_err_evt = rx_cc_valid && seq_chk_en && seq_mismatch;

  // up mode sample events
  wire lmm_evt  = up_mode && rx_lm_request;
  wire cclm_evt = up_mode && rx_cc_valid && rx_cc_lm;
  wire lmr_evt  = up_mode && rx_lm_reply;

  // processor reads that consume an up mode sample
  wire lmm_rd  = up_mode && rd_hit(`CCK_OFS_CAP_TX);
  wire cclm_rd = up_mode && rd_hit(`CCK_OFS_CAP_RX);
  wire lmr_rd  = up_mode && rd_hit(`CCK_OFS_LMR);

  // ----------------------------------------------------------------
  // missed half period count
  // ----------------------------------------------------------------
  reg [2:0] next_miss;

  always @* begin
    next_miss = miss_cnt;
    if (wr_hit(`CCK_OFS_CFG)) begin
      next_miss = reg_wdata[`CCK_F_MISS_HI:`CCK_F_MISS_LO];
    end
    if (half_period_tick && (next_miss != `CCK_MISS_LOC)) begin
      next_miss = next_miss + `CCK_MISS_ONE;
    end
    if (frame_ok) begin
      next_miss = 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // config and status word
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cc_check_config_status <= `CCK_CFG_RESET;
    end else begin
      if (wr_hit(`CCK_OFS_CFG)) begin
        cc_check_config_status <= reg_wdata & `CCK_CFG_WMASK;
      end
      cc_check_config_status[`CCK_F_MISS_HI:`CCK_F_MISS_LO] <= next_miss;
      if (rx_cc_valid) begin
        cc_check_config_status[`CCK_B_PER_ERR]   <= per_err;
        cc_check_config_status[`CCK_B_PRIO_ERR]  <= prio_err;
        cc_check_config_status[`CCK_B_ZERO_ERR]  <= zero_err;
        cc_check_config_status[`CCK_B_RDI]       <= rx_remote_defect;
        cc_check_config_status[`CCK_B_PEER_ERR]  <= peer_err;
        cc_check_config_status[`CCK_B_GROUP_ERR] <= group_err;
        cc_check_config_status[`CCK_B_LEVEL_ERR] <= level_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // pass and fail counters, wrap at full scale
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cc_rx_pass_count <= `CCK_ZERO32;
      cc_rx_fail_count <= `CCK_ZERO32;
    end else begin
      if (frame_ok) begin
        cc_rx_pass_count <= cc_rx_pass_count + `CCK_ONE32;
      end else if (wr_hit(`CCK_OFS_PASS)) begin
        cc_rx_pass_count <= reg_wdata;
      end
      if (rx_cc_valid && frame_bad) begin
        cc_rx_fail_count <= cc_rx_fail_count + `CCK_ONE32;
      end else if (wr_hit(`CCK_OFS_FAIL)) begin
        cc_rx_fail_count <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // loss measurement captures
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      captured_far_tx_count    <= `CCK_ZERO32;
      captured_local_rx_count  <= `CCK_ZERO32;
      up_reply_rx_count_sample <= `CCK_ZERO32;
    end else begin
      if (lmm_evt) begin
        captured_far_tx_count <= rx_lm_counter;
      end else if (!up_mode && rx_cc_valid) begin
        captured_far_tx_count <= rx_far_tx_count;
      end else if (wr_hit(`CCK_OFS_CAP_TX)) begin
        captured_far_tx_count <= reg_wdata;
      end
      if (cclm_evt) begin
        captured_local_rx_count <= rx_lm_counter;
      end else if (!up_mode && rx_cc_valid && rx_cc_lm) begin
        captured_local_rx_count <= rx_frame_counter;
      end else if (wr_hit(`CCK_OFS_CAP_RX)) begin
        captured_local_rx_count <= reg_wdata;
      end
      if (lmr_evt) begin
        up_reply_rx_count_sample <= rx_lm_counter;
      end else if (wr_hit(`CCK_OFS_LMR)) begin
        up_reply_rx_count_sample <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // valid bits and overrun stickies
  // ----------------------------------------------------------------
  wire stat_wr = wr_hit(`CCK_OFS_LM_STAT);

  always @(posedge clk) begin
    if (sys_rst) begin
      lm_request_sample_valid   <= 1'b0;
      cc_lm_sample_valid        <= 1'b0;
      lm_reply_sample_valid     <= 1'b0;
      lm_request_sample_overrun <= 1'b0;
      cc_lm_sample_overrun      <= 1'b0;
      lm_reply_sample_overrun   <= 1'b0;
      rx_sequence_error_sticky  <= 1'b0;
    end else begin
      // a new sample wins over the read that consumes the old one
      lm_request_sample_valid <= sticky_next(lm_request_sample_valid, lmm_evt, lmm_rd);
      cc_lm_sample_valid      <= sticky_next(cc_lm_sample_valid, cclm_evt, cclm_rd);
      lm_reply_sample_valid   <= sticky_next(lm_reply_sample_valid, lmr_evt, lmr_rd);
      lm_request_sample_overrun <= sticky_next(lm_request_sample_overrun,
        lmm_evt && lm_request_sample_valid && !lmm_rd,
        stat_wr && reg_wdata[`CCK_B_LMM_OVR]);
      cc_lm_sample_overrun <= sticky_next(cc_lm_sample_overrun,
        cclm_evt && cc_lm_sample_valid && !cclm_rd,
        stat_wr && reg_wdata[`CCK_B_CCLM_OVR]);
      lm_reply_sample_overrun <= sticky_next(lm_reply_sample_overrun,
        lmr_evt && lm_reply_sample_valid && !lmr_rd,
        stat_wr && reg_wdata[`CCK_B_LMR_OVR]);
      rx_sequence_error_sticky <= sticky_next(rx_sequence_error_sticky, seq_err_evt,
        stat_wr && reg_wdata[`CCK_B_SEQ_ERR]);
    end
  end

  // ----------------------------------------------------------------
  // sequence registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      cc_tx_sequence          <= `CCK_ZERO32;
      cc_rx_expected_sequence <= `CCK_ZERO32;
    end else begin
      if (wr_hit(`CCK_OFS_TX_SEQ)) begin
        cc_tx_sequence <= reg_wdata;
      end
      if (!up_mode && rx_cc_valid) begin
        cc_rx_expected_sequence <= rx_sequence + `CCK_ONE32;
      end else begin
        if (wr_hit(`CCK_OFS_RX_SEQ)) begin
          cc_rx_expected_sequence <= reg_wdata;
        end
        if (up_mode && rx_cc_valid && rx_cc_lm) begin
          cc_rx_expected_sequence[`CCK_F_TAG_CCLM_HI:`CCK_F_TAG_CCLM_LO] <=
            lm_rx_sequence_tag;
        end
        if (lmr_evt && in_service) begin
          cc_rx_expected_sequence[`CCK_F_TAG_LMR_HI:`CCK_F_TAG_LMR_LO] <=
            lm_rx_sequence_tag;
        end
        if (lmm_evt) begin
          cc_rx_expected_sequence[`CCK_F_TAG_LMM_HI:`CCK_F_TAG_LMM_LO] <=
            lm_rx_sequence_tag;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // own configuration
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      expected_peer_id  <= 16'h0000;
      expected_group_id <= `CCK_ZERO32;
      up_mode           <= 1'b0;
      expected_level    <= 3'h0;
    end else begin
      if (wr_hit(`CCK_OFS_PEER_ID)) begin
        expected_peer_id <= reg_wdata[15:0];
      end
      if (wr_hit(`CCK_OFS_GROUP_ID)) begin
        expected_group_id <= reg_wdata;
      end
      if (wr_hit(`CCK_OFS_MODE)) begin
        up_mode        <= reg_wdata[`CCK_B_UP_MODE];
        expected_level <= reg_wdata[`CCK_F_LEVEL_HI:`CCK_F_LEVEL_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and outputs
  // ----------------------------------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = `CCK_ZERO32;
    case (reg_addr)
      `CCK_OFS_CFG:      next_rdata = cc_check_config_status;
      `CCK_OFS_PASS:     next_rdata = cc_rx_pass_count;
      `CCK_OFS_FAIL:     next_rdata = cc_rx_fail_count;
      `CCK_OFS_CAP_TX:   next_rdata = captured_far_tx_count;
      `CCK_OFS_CAP_RX:   next_rdata = captured_local_rx_count;
      `CCK_OFS_LMR:      next_rdata = up_reply_rx_count_sample;
      `CCK_OFS_TX_SEQ:   next_rdata = cc_tx_sequence;
      `CCK_OFS_RX_SEQ:   next_rdata = cc_rx_expected_sequence;
      `CCK_OFS_PEER_ID:  next_rdata[15:0] = expected_peer_id;
      `CCK_OFS_GROUP_ID: next_rdata = expected_group_id;
      `CCK_OFS_MODE: begin
        next_rdata[`CCK_B_UP_MODE] = up_mode;
        next_rdata[`CCK_F_LEVEL_HI:`CCK_F_LEVEL_LO] = expected_level;
      end
      `CCK_OFS_LM_STAT: begin
        next_rdata[`CCK_B_LMM_VLD]  = lm_request_sample_valid;
        next_rdata[`CCK_B_CCLM_VLD] = cc_lm_sample_valid;
        next_rdata[`CCK_B_LMR_VLD]  = lm_reply_sample_valid;
        next_rdata[`CCK_B_LMM_OVR]  = lm_request_sample_overrun;
        next_rdata[`CCK_B_CCLM_OVR] = cc_lm_sample_overrun;
        next_rdata[`CCK_B_LMR_OVR]  = lm_reply_sample_overrun;
        next_rdata[`CCK_B_SEQ_ERR]  = rx_sequence_error_sticky;
      end
      default:           next_rdata = `CCK_ZERO32;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata          <= `CCK_ZERO32;
      tx_sequence        <= `CCK_ZERO32;
      far_tx_count       <= `CCK_ZERO32;
      local_rx_count     <= `CCK_ZERO32;
      loss_of_continuity <= 1'b0;
    end else begin
      reg_rdata          <= reg_rd ? next_rdata : `CCK_ZERO32;
      tx_sequence        <= cc_tx_sequence;
      far_tx_count       <= captured_far_tx_count;
      local_rx_count     <= captured_local_rx_count;
      loss_of_continuity <= (next_miss == `CCK_MISS_LOC);
    end
  end

endmodule // cck_rx_check_lm_capture

`default_nettype wire

// ---- tb/cck_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cck_consts.vh"

module cck_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // frame side
  input wire logic        rx_cc_valid,
  input wire logic        rx_cc_lm,
  input wire logic [31:0] rx_far_tx_count,
  input wire logic        rx_lm_request,
  input wire logic [31:0] rx_frame_counter,
  input wire logic [31:0] rx_lm_counter,
  input wire logic        half_period_tick,
  // transmit side
  input wire logic [31:0] tx_sequence,
  input wire logic [31:0] far_tx_count,
  input wire logic [31:0] local_rx_count,
  input wire logic        loss_of_continuity
);
  logic up_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // mode shadow
  // ------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      up_mode <= 1'b0;
    end else if (reg_wr && reg_addr == `CCK_OFS_MODE) begin
      up_mode <= reg_wdata[`CCK_B_UP_MODE];
    end
  end
  sequence hold_s;
    !rx_cc_valid && !rx_lm_request && !reg_wr;
  endsequence
  sequence down_frame_s;
    (rx_cc_valid && !up_mode) ##1 hold_s;
  endsequence
  // ------------------------------
  // assertions
  // ------------------------------
  down_far_tx_a: assert property (down_frame_s |-> ##1 far_tx_count == $past(rx_far_tx_count, 2))
    else $error("far tx count not captured");
  down_local_rx_a: assert property ((rx_cc_valid && rx_cc_lm && !up_mode) ##1 hold_s
    |-> ##1 local_rx_count == $past(rx_frame_counter, 2)) else $error("rx frame count not captured");
  up_lmm_cap_a: assert property ((rx_lm_request && up_mode) ##1 hold_s
    |-> ##1 far_tx_count == $past(rx_lm_counter, 2)) else $error("lm request sample wrong");
  up_cclm_cap_a: assert property ((rx_cc_valid && rx_cc_lm && up_mode) ##1 hold_s
    |-> ##1 local_rx_count == $past(rx_lm_counter, 2)) else $error("cc lm sample wrong");
  tx_seq_copy_a: assert property (reg_wr && reg_addr == `CCK_OFS_TX_SEQ
    |-> ##2 tx_sequence == $past(reg_wdata, 2)) else $error("tx sequence not forwarded");
  tx_seq_read_a: assert property (reg_rd && reg_addr == `CCK_OFS_TX_SEQ
    |=> reg_rdata == tx_sequence) else $error("tx sequence read differs");
  cap_read_a: assert property (reg_rd && reg_addr == `CCK_OFS_CAP_TX
    |=> reg_rdata == far_tx_count) else $error("capture read differs");
  loss_rise_a: assert property ($rose(loss_of_continuity) |-> $past(half_period_tick))
    else $error("loss rose without tick");
  loss_hold_a: assert property (loss_of_continuity && !rx_cc_valid && !reg_wr
    |=> loss_of_continuity) else $error("loss dropped without cause");
endmodule // cck_checker

bind cck_rx_check_lm_capture cck_checker chk_u (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_cc_valid(rx_cc_valid),
  .rx_cc_lm(rx_cc_lm), .rx_far_tx_count(rx_far_tx_count), .rx_lm_request(rx_lm_request),
  .rx_frame_counter(rx_frame_counter), .rx_lm_counter(rx_lm_counter),
  .half_period_tick(half_period_tick), .tx_sequence(tx_sequence),
  .far_tx_count(far_tx_count), .local_rx_count(local_rx_count),
  .loss_of_continuity(loss_of_continuity)
);
`default_nettype wire

// ---- tb/cck_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module cck_peer_model (
  // clock
  input  wire logic        clk,
  // frame and events
  output var  logic        rx_cc_valid,
  output wire logic        rx_cc_lm,
  output wire logic [15:0] rx_peer_id,
  output wire logic [31:0] rx_group_id,
  output wire logic [2:0]  rx_period,
  output wire logic [2:0]  rx_priority,
  output wire logic [2:0]  rx_level,
  output wire logic        rx_remote_defect,
  output wire logic [31:0] rx_sequence,
  output wire logic [31:0] rx_far_tx_count,
  output wire logic [4:0]  lm_rx_sequence_tag,
  output var  logic        rx_lm_request,
  output var  logic        rx_lm_reply
);
  logic [127:0] fld = 128'h0;
  assign {rx_cc_lm, rx_peer_id, rx_group_id, rx_period, rx_priority, rx_level,
          rx_remote_defect, rx_sequence, rx_far_tx_count, lm_rx_sequence_tag} = fld;
  initial begin
    rx_cc_valid = 1'b0;
    rx_lm_request = 1'b0;
    rx_lm_reply = 1'b0;
  end
  // ------------------------------
  // senders; fields invert once stale
  // ------------------------------
  task automatic frame(input logic lm, input logic [15:0] id, input logic [31:0] grp,
                       input logic [2:0] per, input logic [2:0] pri, input logic [2:0] lvl,
                       input logic rdi, input logic [31:0] seq);
    @(posedge clk);
    rx_cc_valid <= 1'b1;
    fld <= {lm, id, grp, per, pri, lvl, rdi, seq, ~seq, seq[4:0]};
    @(posedge clk);
    rx_cc_valid <= 1'b0;
    fld <= ~fld;
  endtask
  task automatic lm_event(input logic reply, input logic [4:0] tag);
    @(posedge clk);
    rx_lm_request <= !reply;
    rx_lm_reply <= reply;
    fld[4:0] <= tag;
    @(posedge clk);
    rx_lm_request <= 1'b0;
    rx_lm_reply <= 1'b0;
    fld[4:0] <= ~tag;
  endtask
endmodule // cck_peer_model
`default_nettype wire

// ---- tb/cck_rx_check_lm_capture_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cck_consts.vh"

module cck_rx_check_lm_capture_tb;
  localparam logic [31:0] GRP = 32'h1234_5678;
  localparam logic [31:0] FCNT = 32'h00a5_5a01;
  localparam logic [47:0] BP = {8'h00, 8'h06, 8'h07, 8'h05, 8'h01, 8'h02};
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        in_service = 1'b0, half_period_tick = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, rx_frame_counter = FCNT, rx_lm_counter = 32'h0000_0000;
  logic [31:0] reg_rdata, tx_sequence, far_tx_count, local_rx_count;
  logic [31:0] rx_group_id, rx_sequence, rx_far_tx_count;
  logic        loss_of_continuity, rx_cc_valid, rx_cc_lm, rx_remote_defect;
  logic        rx_lm_request, rx_lm_reply;
  logic [15:0] rx_peer_id;
  logic [2:0]  rx_period, rx_priority, rx_level;
  logic [4:0]  lm_rx_sequence_tag;
  int          err_count = 0;
  int          n_tests = 0;
  always #2.5 clk = ~clk;
  cck_rx_check_lm_capture dut_u (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_cc_valid(rx_cc_valid), .rx_cc_lm(rx_cc_lm),
    .rx_peer_id(rx_peer_id), .rx_group_id(rx_group_id), .rx_period(rx_period),
    .rx_priority(rx_priority), .rx_level(rx_level), .rx_remote_defect(rx_remote_defect),
    .rx_sequence(rx_sequence), .rx_far_tx_count(rx_far_tx_count),
    .rx_lm_request(rx_lm_request), .rx_lm_reply(rx_lm_reply),
    .lm_rx_sequence_tag(lm_rx_sequence_tag), .in_service(in_service),
    .rx_frame_counter(rx_frame_counter), .rx_lm_counter(rx_lm_counter),
    .half_period_tick(half_period_tick), .tx_sequence(tx_sequence),
    .far_tx_count(far_tx_count), .local_rx_count(local_rx_count),
    .loss_of_continuity(loss_of_continuity));
  cck_peer_model peer_u (
    .clk(clk), .rx_cc_valid(rx_cc_valid), .rx_cc_lm(rx_cc_lm), .rx_peer_id(rx_peer_id),
    .rx_group_id(rx_group_id), .rx_period(rx_period), .rx_priority(rx_priority),
    .rx_level(rx_level), .rx_remote_defect(rx_remote_defect), .rx_sequence(rx_sequence),
    .rx_far_tx_count(rx_far_tx_count), .lm_rx_sequence_tag(lm_rx_sequence_tag),
    .rx_lm_request(rx_lm_request), .rx_lm_reply(rx_lm_reply));
  // ------------------------------
  // bus and compare helpers
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask
  task automatic good(input logic lm, input logic [15:0] id, input logic [31:0] seq);
    peer_u.frame(lm, id, GRP, 3'h3, 3'h5, 3'h2, 1'b1, seq);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    rd(`CCK_OFS_CFG, `CCK_CFG_RESET, "cfg");
    rd(`CCK_OFS_PASS, `CCK_ZERO32, "pass");
    rd(8'h30, `CCK_ZERO32, "unmapped");
  endtask
  task automatic t_checks();
    wr(`CCK_OFS_PEER_ID, 32'h0000_0012);
    wr(`CCK_OFS_GROUP_ID, GRP);
    wr(`CCK_OFS_MODE, 32'h0000_0004);
    wr(`CCK_OFS_CFG, 32'h0000_af00);
    good(1'b0, 16'h0012, `CCK_ZERO32);
    rd(`CCK_OFS_CFG, 32'h0000_af10, "cfg good");
    for (int i = 0; i < 6; i++) begin
      peer_u.frame(1'b0, (i == 0) ? 16'h0013 : 16'h0012, (i == 1) ? ~GRP : GRP,
                   (i == 2) ? 3'h0 : (i == 3) ? 3'h4 : 3'h3, (i == 4) ? 3'h4 : 3'h5,
                   (i == 5) ? 3'h3 : 3'h2, 1'b0, `CCK_ZERO32);
      rd(`CCK_OFS_CFG, 32'h0000_af00 | (`CCK_ONE32 << BP[i*8 +: 8]), "cfg bad");
    end
    rd(`CCK_OFS_FAIL, 32'h0000_0006, "fail");
    wr(`CCK_OFS_CFG, 32'h0000_ae00);
    good(1'b0, 16'h0099, `CCK_ZERO32);
    rd(`CCK_OFS_CFG, 32'h0000_ae10, "cfg no id");
    rd(`CCK_OFS_PASS, 32'h0000_0002, "pass");
  endtask
  task automatic t_miss();
    repeat (8) begin
      @(posedge clk);
      half_period_tick <= 1'b1;
      @(posedge clk);
      half_period_tick <= 1'b0;
    end
    rd(`CCK_OFS_CFG, 32'h0007_ae10, "miss sat");
    chk("loss", `CCK_ONE32, {31'h0, loss_of_continuity});
    peer_u.frame(1'b0, 16'h0012, GRP, 3'h3, 3'h5, 3'h3, 1'b0, `CCK_ZERO32);
    rd(`CCK_OFS_CFG, 32'h0007_ae01, "miss kept");
    good(1'b0, 16'h0012, `CCK_ZERO32);
    rd(`CCK_OFS_CFG, 32'h0000_ae10, "miss clr");
    chk("loss", `CCK_ZERO32, {31'h0, loss_of_continuity});
    wr(`CCK_OFS_PASS, 32'hffff_ffff);
    good(1'b0, 16'h0012, `CCK_ZERO32);
    rd(`CCK_OFS_PASS, `CCK_ZERO32, "pass wrap");
  endtask
  task automatic t_down();
    wr(`CCK_OFS_CFG, 32'h0010_ae00);
    wr(`CCK_OFS_RX_SEQ, 32'h0000_0010);
    good(1'b1, 16'h0012, 32'h0000_0010);
    rd(`CCK_OFS_LM_STAT, `CCK_ZERO32, "seq ok");
    chk("far tx", 32'hffff_ffef, far_tx_count);
    chk("local rx", FCNT, local_rx_count);
    good(1'b0, 16'h0012, 32'h0000_0020);
    rd(`CCK_OFS_RX_SEQ, 32'h0000_0021, "rx seq");
    rd(`CCK_OFS_LM_STAT, 32'h0000_0100, "seq err");
    wr(`CCK_OFS_LM_STAT, 32'h0000_0100);
    wr(`CCK_OFS_TX_SEQ, 32'hcafe_0001);
    rd(`CCK_OFS_TX_SEQ, 32'hcafe_0001, "tx seq");
    chk("tx seq out", 32'hcafe_0001, tx_sequence);
  endtask
  task automatic t_up();
    @(posedge clk);
    in_service <= 1'b1;
    rx_lm_counter <= 32'h0000_1111;
    wr(`CCK_OFS_MODE, 32'h0000_0005);
    peer_u.lm_event(1'b0, 5'h03);
    rd(`CCK_OFS_LM_STAT, `CCK_ONE32, "lmm vld");
    @(posedge clk);
    rx_lm_counter <= 32'h0000_2222;
    peer_u.lm_event(1'b0, 5'h04);
    rd(`CCK_OFS_CAP_TX, 32'h0000_2222, "lmm cap");
    rd(`CCK_OFS_LM_STAT, 32'h0000_0010, "lmm ovr");
    good(1'b1, 16'h0012, 32'h7777_0021);
    rd(`CCK_OFS_RX_SEQ, 32'h1001_0021, "up tags");
    rd(`CCK_OFS_LM_STAT, 32'h0000_0012, "up seq ok");
    good(1'b1, 16'h0012, 32'h0000_0022);
    peer_u.lm_event(1'b1, 5'h06);
    rd(`CCK_OFS_LM_STAT, 32'h0000_0136, "up stat");
    rd(`CCK_OFS_LMR, 32'h0000_2222, "lmr cap");
    rd(`CCK_OFS_RX_SEQ, 32'h10c2_0021, "lmr tag");
    @(posedge clk);
    in_service <= 1'b0;
    peer_u.lm_event(1'b1, 5'h09);
    rd(`CCK_OFS_RX_SEQ, 32'h10c2_0021, "lmr tag kept");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_checks();
    t_miss();
    t_down();
    t_up();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule // cck_rx_check_lm_capture_tb
`default_nettype wire
